/* logic/rpm_params.svh */
/*
  Constants of the reset and power-mode sequencer: register map, field
  positions, reset values and cycle counts.
  Assumes inclusion by the package and the design modules by bare name.
*/
`ifndef RPM_PARAMS_SVH
`define RPM_PARAMS_SVH

// ----------------------------------------
// clocking figures
// ----------------------------------------
`define RPM_MASTER_MHZ 120
`define RPM_DERIVED_MHZ 60
`define RPM_POR_EXT_CYCLES 2097152
`define RPM_CNT_W 22
`define RPM_WIN_LAST 22'h00001f

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define RPM_OFS_CTRL 8'h00
`define RPM_OFS_PCE 8'h04
`define RPM_OFS_STAT 8'h08

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define RPM_B_STOP_DIS 0
`define RPM_B_STOP_PERM 1
`define RPM_B_WAIT_DIS 2
`define RPM_B_WAIT_PERM 3
`define RPM_B_SW_RST 4
`define RPM_B_CLKO_DIS 5
`define RPM_B_DBG_EN 6
`define RPM_CTRL_RST 7'h00
`define RPM_PCE_RST 16'hffff
`define RPM_SEC_OPEN 16'hffff

`endif

/* logic/rpm_pkg.sv */
/*
  Types of the reset and power-mode sequencer: modes, sequence states and
  the packed state records of each module.
  Assumes rpm_params.svh on the include path.
*/
`include "rpm_params.svh"

package rpm_pkg;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_STOP = 2'b10
  } rpm_mode_t;

  typedef enum logic [2:0] {
    SEQ_POR = 3'b000,
    SEQ_CLK = 3'b001,
    SEQ_PERIPH = 3'b010,
    SEQ_CORE = 3'b011,
    SEQ_DONE = 3'b100
  } rpm_seq_t;

  typedef struct packed {
    logic f1;
    logic f2;
    logic f3;
    logic o;
  } rpm_sync_t;

  typedef struct packed {
    rpm_seq_t st;
    logic [`RPM_CNT_W-1:0] cnt;
    logic clk_run;
    logic prst_n;
    logic crst_n;
    logic fetch;
    logic sample;
  } rpm_seq_state_t;

  typedef struct packed {
    rpm_mode_t mode;
    logic [6:0] ctrl;
    logic [15:0] pce;
    logic ack;
    logic [15:0] rdata;
    logic sw_rst;
    logic can_drop;
    logic secured;
    logic half_clk;
  } rpm_top_state_t;

endpackage

/* logic/rpm_rst_seq.sv */
/*
  Reset release sequencer: power-on extension, then three windows that start
  clocking, release peripherals and initialise the core.
  Assumes restart is a synchronous level from logic on system_clock.
*/
`timescale 1ns/1ps
`include "rpm_params.svh"

module rpm_rst_seq #(
  parameter int POR_EXT_CYCLES = `RPM_POR_EXT_CYCLES
) (
  // clock and reset
  input wire logic system_clock,
  input wire logic reset_n,
  // synchronous reset sources merged
  input wire logic restart,
  // release outputs
  output logic clk_run,
  output logic prst_n,
  output logic crst_n,
  output logic fetch,
  output logic sample
);

  localparam logic [`RPM_CNT_W-1:0] POR_LAST = `RPM_CNT_W'(POR_EXT_CYCLES - 1);

  rpm_pkg::rpm_seq_state_t s;
  rpm_pkg::rpm_seq_state_t next_s;
  logic [`RPM_CNT_W-1:0] last;

  always_comb
  begin
    next_s = s;
    next_s.sample = 1'b0;
    last = (s.st == rpm_pkg::SEQ_POR) ? POR_LAST : `RPM_WIN_LAST;
    // a late source must not cut the power-on extension short
    if (restart && s.st != rpm_pkg::SEQ_POR)
    begin
      next_s = '{st: rpm_pkg::SEQ_CLK, cnt: '0, clk_run: 1'b1, prst_n: 1'b0,
                 crst_n: 1'b0, fetch: 1'b0, sample: 1'b0};
    end
    else if (s.st != rpm_pkg::SEQ_DONE && s.cnt != last)
    begin
      next_s.cnt = s.cnt + `RPM_CNT_W'(1);
    end
    else
    begin
      next_s.cnt = '0;
      case (s.st)
        rpm_pkg::SEQ_POR:
        begin
          next_s.st = rpm_pkg::SEQ_CLK;
          next_s.clk_run = 1'b1;
        end
        rpm_pkg::SEQ_CLK:
        begin
          next_s.st = rpm_pkg::SEQ_PERIPH;
          next_s.prst_n = 1'b1;
          next_s.sample = 1'b1;
        end
        rpm_pkg::SEQ_PERIPH:
        begin
          next_s.st = rpm_pkg::SEQ_CORE;
          next_s.crst_n = 1'b1;
        end
        rpm_pkg::SEQ_CORE:
        begin
          next_s.st = rpm_pkg::SEQ_DONE;
          next_s.fetch = 1'b1;
        end
        default:
        begin
          next_s.st = rpm_pkg::SEQ_DONE;
        end
      endcase
    end
  end

  // assertion is asynchronous, every release lands on a rising edge
  always_ff @(posedge system_clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= '{st: rpm_pkg::SEQ_POR, cnt: '0, clk_run: 1'b0, prst_n: 1'b0,
             crst_n: 1'b0, fetch: 1'b0, sample: 1'b0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign clk_run = s.clk_run;
  assign prst_n = s.prst_n;
  assign crst_n = s.crst_n;
  assign fetch = s.fetch;
  assign sample = s.sample;

endmodule

/* logic/rpm_sequencer.sv */
/*
  Reset and power-mode sequencer top: clock enables, run/wait/stop modes with
  wake-up, sleep disable, merged reset sources, debug blocking, and a classic
  Wishbone slave for control, clock enable and status words.
  Assumes one 120 MHz system_clock; reset_n is power-on reset, ext_reset_n, can_rx_activity and nonclk_irq asynchronous.
*/
// What this block does
// - derived clocks run at half master rate
// - modes and enables pick running clocks
// - run mode keeps core and peripherals clocked
// - wait stops core, memory; peripherals keep running
// - interrupt in wait resumes core execution
// - stop exits on CAN, irq, resets only
// - CAN wake discards the first message
// - peripherals except watchdog use bus clock
// - PLL never shut down automatically at stop
// - control word disables stop and wait
// - four reset sources, two async two sync
// - software reset from control register write
// - power-on reset extended by 2^21 cycles
// - three 32-clock release windows in order
// - core fetches code after sequence ends
// - async assertion, release on rising edge
// - security state from two flash bytes
// - security blocks debug, not normal execution
// - per-peripheral clock enable, 1 runs it
`timescale 1ns/1ps
`include "rpm_params.svh"

module rpm_sequencer #(
  parameter int POR_EXT_CYCLES = `RPM_POR_EXT_CYCLES
) (
  // clock and power-on reset
  input wire logic system_clock,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // other reset sources
  input wire logic ext_reset_n,
  input wire logic wdog_reset,
  // core sleep requests and interrupts
  input wire logic stop_req,
  input wire logic wait_req,
  input wire logic irq_pending,
  // stop wake-up pins and CAN message hand-off
  input wire logic can_rx_activity,
  input wire logic nonclk_irq,
  input wire logic can_msg_done,
  // flash security bytes
  input wire logic [7:0] sec_byte0,
  input wire logic [7:0] sec_byte1,
  // clocks and enables
  output logic half_clk,
  output logic core_clk_en,
  output logic [15:0] periph_clk_en,
  output logic wdog_clk_en,
  output logic clk_out_en,
  output logic debug_enable,
  // reset releases
  output logic sim_clk_run,
  output logic periph_rst_n,
  output logic core_rst_n,
  output logic core_fetch_en,
  // status
  output logic can_drop_first,
  output logic secured,
  output rpm_pkg::rpm_mode_t power_mode
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] rpm_merge(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
    begin
      r[7:0] = wd[7:0];
    end
    if (sel[1])
    begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  rpm_pkg::rpm_top_state_t q;
  rpm_pkg::rpm_top_state_t next_q;
  logic ext_ok;
  logic can_s;
  logic irq_s;
  logic restart;
  logic seq_run;
  logic seq_prst_n;
  logic seq_crst_n;
  logic seq_fetch;
  logic seq_sample;
  logic hit;
  logic wr;
  logic [15:0] wd;
  logic [15:0] rd;
  logic stop_blocked;
  logic wait_blocked;
  logic wake_stop;

  // ----------------------------------------
  // pin synchronisers and reset merge
  // ----------------------------------------
  rpm_sync #(.RST_VAL(1'b0)) u_ext (
    .system_clock(system_clock),
    .reset_n(reset_n),
    .din(ext_reset_n),
    .dout(ext_ok)
  );

  rpm_sync #(.RST_VAL(1'b0)) u_can (
    .system_clock(system_clock),
    .reset_n(reset_n),
    .din(can_rx_activity),
    .dout(can_s)
  );

  rpm_sync #(.RST_VAL(1'b0)) u_irq (
    .system_clock(system_clock),
    .reset_n(reset_n),
    .din(nonclk_irq),
    .dout(irq_s)
  );

  // power-on reset is reset_n itself; the rest restart the windows
  assign restart = q.sw_rst | wdog_reset | !ext_ok;

  rpm_rst_seq #(.POR_EXT_CYCLES(POR_EXT_CYCLES)) u_seq (
    .system_clock(system_clock),
    .reset_n(reset_n),
    .restart(restart),
    .clk_run(seq_run),
    .prst_n(seq_prst_n),
    .crst_n(seq_crst_n),
    .fetch(seq_fetch),
    .sample(seq_sample)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  assign hit = wb_cyc_i & wb_stb_i & !q.ack;
  assign wr = hit & wb_we_i;
  assign stop_blocked = q.ctrl[`RPM_B_STOP_DIS] | q.ctrl[`RPM_B_STOP_PERM];
  assign wait_blocked = q.ctrl[`RPM_B_WAIT_DIS] | q.ctrl[`RPM_B_WAIT_PERM];
  assign wake_stop = can_s | irq_s;

  always_comb
  begin
    next_q = q;
    next_q.half_clk = !q.half_clk;
    next_q.ack = hit;
    next_q.sw_rst = 1'b0;
    wd = rpm_merge({9'h000, q.ctrl}, wb_dat_i, wb_sel_i);
    if (wb_adr_i == `RPM_OFS_CTRL)
    begin
      rd = {9'h000, q.ctrl};
    end
    else if (wb_adr_i == `RPM_OFS_PCE)
    begin
      rd = q.pce;
    end
    else if (wb_adr_i == `RPM_OFS_STAT)
    begin
      rd = {10'h000, seq_fetch, seq_prst_n, q.can_drop, q.secured, q.mode};
    end
    else
    begin
      rd = 16'h0000;
    end
    if (hit)
    begin
      next_q.rdata = wb_we_i ? 16'h0000 : rd;
    end
    if (wr && wb_adr_i == `RPM_OFS_CTRL)
    begin
      next_q.ctrl = wd[6:0];
      next_q.ctrl[`RPM_B_SW_RST] = 1'b0;
      next_q.ctrl[`RPM_B_STOP_PERM] = q.ctrl[`RPM_B_STOP_PERM] | wd[`RPM_B_STOP_PERM];
      next_q.ctrl[`RPM_B_WAIT_PERM] = q.ctrl[`RPM_B_WAIT_PERM] | wd[`RPM_B_WAIT_PERM];
      next_q.sw_rst = wd[`RPM_B_SW_RST];
    end
    if (wr && wb_adr_i == `RPM_OFS_PCE)
    begin
      next_q.pce = rpm_merge(q.pce, wb_dat_i, wb_sel_i);
    end
    // power modes
    case (q.mode)
      rpm_pkg::MODE_RUN:
      begin
        // the PLL is left alone here; software parks it before stop
        if (seq_fetch && stop_req && !stop_blocked)
        begin
          next_q.mode = rpm_pkg::MODE_STOP;
        end
        else if (seq_fetch && wait_req && !wait_blocked)
        begin
          next_q.mode = rpm_pkg::MODE_WAIT;
        end
      end
      rpm_pkg::MODE_WAIT:
      begin
        if (irq_pending)
        begin
          next_q.mode = rpm_pkg::MODE_RUN;
        end
      end
      rpm_pkg::MODE_STOP:
      begin
        if (wake_stop)
        begin
          next_q.mode = rpm_pkg::MODE_RUN;
        end
      end
      default:
      begin
        next_q.mode = rpm_pkg::MODE_RUN;
      end
    endcase
    // set wins over the clear by a finished message
    next_q.can_drop = (q.mode == rpm_pkg::MODE_STOP && can_s) | (q.can_drop & !can_msg_done);
    if (seq_sample)
    begin
      next_q.secured = {sec_byte1, sec_byte0} != `RPM_SEC_OPEN;
    end
    // watchdog, external and software resets also end stop
    if (restart)
    begin
      next_q.mode = rpm_pkg::MODE_RUN;
      next_q.ctrl = `RPM_CTRL_RST;
      next_q.pce = `RPM_PCE_RST;
    end
  end

  always_ff @(posedge system_clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '{mode: rpm_pkg::MODE_RUN, ctrl: `RPM_CTRL_RST, pce: `RPM_PCE_RST, ack: 1'b0,
             rdata: 16'h0000, sw_rst: 1'b0, can_drop: 1'b0, secured: 1'b1, half_clk: 1'b0};
    end
    else
    begin
      q <= next_q;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_dat_o = {16'h0000, q.rdata};
  assign wb_ack_o = q.ack;
  assign half_clk = q.half_clk;
  assign core_clk_en = seq_run & (q.mode == rpm_pkg::MODE_RUN);
  // bus clock feeds every peripheral but the watchdog, which also runs in stop
  assign periph_clk_en = (seq_run && q.mode != rpm_pkg::MODE_STOP) ? q.pce : 16'h0000;
  assign wdog_clk_en = seq_run;
  assign clk_out_en = seq_run & !q.ctrl[`RPM_B_CLKO_DIS];
  assign debug_enable = seq_run & q.ctrl[`RPM_B_DBG_EN] & !q.secured;
  assign sim_clk_run = seq_run;
  // the pin pulls resets low at once; release waits for the sequencer
  assign periph_rst_n = seq_prst_n & ext_reset_n;
  assign core_rst_n = seq_crst_n & ext_reset_n;
  assign core_fetch_en = seq_fetch & ext_reset_n;
  assign can_drop_first = q.can_drop;
  assign secured = q.secured;
  assign power_mode = q.mode;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge system_clock); endclocking
  default disable iff (!reset_n);

  a_half_clk_toggle: assert property ($past(reset_n) |-> half_clk != $past(half_clk))
    else $error("half clock did not toggle");
  a_run_clocks_on: assert property (seq_run && power_mode == rpm_pkg::MODE_RUN |-> core_clk_en)
    else $error("core clock off in run");
  a_wait_core_off: assert property (power_mode == rpm_pkg::MODE_WAIT |-> !core_clk_en &&
    periph_clk_en == (seq_run ? q.pce : 16'h0000))
    else $error("wait clocks wrong");
  a_wait_irq_wake: assert property (power_mode == rpm_pkg::MODE_WAIT && irq_pending |=>
    power_mode == rpm_pkg::MODE_RUN)
    else $error("interrupt did not end wait");
  a_stop_held: assert property (power_mode == rpm_pkg::MODE_STOP && !can_s && !irq_s &&
    !restart |=> power_mode == rpm_pkg::MODE_STOP && periph_clk_en == 16'h0000)
    else $error("stop left without a wake event");
  a_can_drop_set: assert property (power_mode == rpm_pkg::MODE_STOP && can_s |=>
    can_drop_first && power_mode == rpm_pkg::MODE_RUN)
    else $error("first message not marked for drop");
  a_stop_disable: assert property (power_mode == rpm_pkg::MODE_RUN && stop_blocked &&
    !(wait_req && !wait_blocked) |=> power_mode == rpm_pkg::MODE_RUN)
    else $error("stop entered while disabled");
  a_sw_reset_seq: assert property (wr && wb_adr_i == `RPM_OFS_CTRL && wb_sel_i[0] &&
    wb_dat_i[`RPM_B_SW_RST] |-> ##2 !periph_rst_n && !core_rst_n)
    else $error("software reset not applied");
  a_core_window: assert property ($rose(seq_crst_n) |-> !seq_fetch ##31 !seq_fetch ##1 seq_fetch)
    else $error("core window not 32 cycles");
  a_periph_window: assert property ($rose(seq_prst_n) |-> seq_crst_n == 1'b0 [*8])
    else $error("core released with peripherals");
  a_secure_debug: assert property (q.secured |-> !debug_enable)
    else $error("debug open while secured");
  a_pce_gate: assert property (seq_run && power_mode == rpm_pkg::MODE_RUN |-> periph_clk_en == q.pce)
    else $error("peripheral enable ignored");

  c_wait_wake: cover property (power_mode == rpm_pkg::MODE_WAIT ##1 power_mode == rpm_pkg::MODE_RUN);
  c_can_wake: cover property (power_mode == rpm_pkg::MODE_STOP && can_s ##1 can_drop_first);
  c_sw_reset: cover property (q.sw_rst ##[1:200] $rose(core_fetch_en));
  c_stop_blocked: cover property (stop_req && stop_blocked && power_mode == rpm_pkg::MODE_RUN);

endmodule

/* logic/rpm_sync.sv */
/*
  Three-flop synchroniser for a pin level; the output moves only once the
  second and third flops agree.
  Assumes a single clock domain on system_clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "rpm_params.svh"

module rpm_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic system_clock,
  input wire logic reset_n,
  // level in and out
  input wire logic din,
  output logic dout
);

  rpm_pkg::rpm_sync_t s;
  rpm_pkg::rpm_sync_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.f1 = din;
    next_s.f2 = s.f1;
    next_s.f3 = s.f2;
    // f1 feeds f2 alone; the filter only looks at f2 and f3
    if (s.f2 == s.f3)
    begin
      next_s.o = s.f3;
    end
  end

  always_ff @(posedge system_clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= rpm_pkg::rpm_sync_t'({4{RST_VAL}});
    end
    else
    begin
      s <= next_s;
    end
  end

  assign dout = s.o;

endmodule

/* verif/rpm_core_model.sv */
/*
  Model of the processor core beside the sequencer: sleep instruction
  pulses, an interrupt level and the CAN message hand-off.
  Assumes one system_clock; the bench calls the tasks from its own sequence.
*/
`timescale 1ns/1ps

module rpm_core_model (
  // clock
  input wire logic system_clock,
  // core requests towards the sequencer
  output logic stop_req,
  output logic wait_req,
  output logic irq_pending,
  output logic can_msg_done
);
  initial
  begin
    stop_req = 1'b0;
    wait_req = 1'b0;
    irq_pending = 1'b0;
    can_msg_done = 1'b0;
  end

  // ----------------------------------------
  // sleep instructions, one pulse each
  // ----------------------------------------
  // no pll handling here: clock source switch assumed done before stop
  task automatic sleep(input logic is_stop);
    @(posedge system_clock);
    stop_req <= is_stop;
    wait_req <= ~is_stop;
    @(posedge system_clock);
    stop_req <= 1'b0;
    wait_req <= 1'b0;
  endtask

  // unmasked interrupt held for a few cycles
  task automatic irq(input int n);
    @(posedge system_clock);
    irq_pending <= 1'b1;
    repeat (n) @(posedge system_clock);
    irq_pending <= 1'b0;
  endtask

  // message consumed by the CAN receiver
  task automatic msg_done();
    @(posedge system_clock);
    can_msg_done <= 1'b1;
    @(posedge system_clock);
    can_msg_done <= 1'b0;
  endtask
endmodule

/* verif/rpm_sequencer_test.sv */
/*
  Self-checking bench of the reset and power-mode sequencer.
  Assumes the core model beside it and a shortened power-on extension.
*/
`timescale 1ns/1ps

module rpm_sequencer_test;
  localparam int POR_EXT = 16;
  localparam int TMO = 20000;
  logic system_clock, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, sec_byte0, sec_byte1;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic ext_reset_n, wdog_reset, stop_req, wait_req, irq_pending;
  logic can_rx_activity, nonclk_irq, can_msg_done, half_clk, core_clk_en;
  logic [15:0] periph_clk_en;
  logic wdog_clk_en, clk_out_en, debug_enable, sim_clk_run, periph_rst_n;
  logic core_rst_n, core_fetch_en, can_drop_first, secured;
  rpm_pkg::rpm_mode_t power_mode;
  int err_total = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  int n;
  logic [3:0] sel_v = 4'h3;

  rpm_sequencer #(.POR_EXT_CYCLES(POR_EXT)) dut_u (.system_clock(system_clock), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_reset_n(ext_reset_n), .wdog_reset(wdog_reset), .stop_req(stop_req),
    .wait_req(wait_req), .irq_pending(irq_pending), .can_rx_activity(can_rx_activity),
    .nonclk_irq(nonclk_irq), .can_msg_done(can_msg_done), .sec_byte0(sec_byte0),
    .sec_byte1(sec_byte1), .half_clk(half_clk), .core_clk_en(core_clk_en),
    .periph_clk_en(periph_clk_en), .wdog_clk_en(wdog_clk_en), .clk_out_en(clk_out_en),
    .debug_enable(debug_enable), .sim_clk_run(sim_clk_run), .periph_rst_n(periph_rst_n),
    .core_rst_n(core_rst_n), .core_fetch_en(core_fetch_en), .can_drop_first(can_drop_first),
    .secured(secured), .power_mode(power_mode));

  rpm_core_model core_u (.system_clock(system_clock), .stop_req(stop_req), .wait_req(wait_req),
    .irq_pending(irq_pending), .can_msg_done(can_msg_done));

  // ----------------------------------------
  // clock, timeout, closing
  // ----------------------------------------
  initial
  begin
    system_clock = 1'b0;
    forever #50 system_clock = ~system_clock;
  end

  task automatic report_and_stop();
    $display("compares %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge system_clock)
  begin
    cyc_cnt++;
    if (cyc_cnt == TMO)
    begin
      err_total++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic cycle; holds until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [15:0] dat);
    int k;
    @(posedge system_clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel_v;
    wb_adr_i <= adr;
    wb_dat_i <= {16'h0000, dat};
    k = 0;
    do
    begin
      @(posedge system_clock);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50)
      check(32'h0000dead, 32'h00000000);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 16'h0000);
    check(rd, exp);
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return sim_clk_run;
      1: return periph_rst_n;
      2: return core_rst_n;
      3: return core_fetch_en;
      default: return power_mode === rpm_pkg::MODE_RUN;
    endcase
  endfunction

  // cycles until the chosen output reaches v, bounded
  task automatic cnt_to(input int w, input logic v, output int c);
    c = 0;
    while (pick(w) !== v && c < 3000)
    begin
      @(posedge system_clock);
      #1;
      c++;
    end
  endtask

  task automatic seq_chk();
    cnt_to(1, 1'b1, n);
    cnt_to(2, 1'b1, n);
    check(n, 32);
    cnt_to(3, 1'b1, n);
    check(n, 32);
  endtask

  task automatic pulse_wdog();
    @(posedge system_clock);
    wdog_reset <= 1'b1;
    @(posedge system_clock);
    wdog_reset <= 1'b0;
    #1;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wdog_reset, can_rx_activity, nonclk_irq} = '0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h00000000;
    ext_reset_n = 1'b1;
    sec_byte0 = 8'hff;
    sec_byte1 = 8'hff;
    repeat (20) @(posedge system_clock);
    check({half_clk, core_rst_n, periph_clk_en, secured}, 32'h00000001);
    reset_n <= 1'b1;
    #1;
    cnt_to(0, 1'b1, n);
    check(n >= POR_EXT, 1'b1);
    cnt_to(1, 1'b1, n);
    check(n, 32);
    cnt_to(2, 1'b1, n);
    check(n, 32);
    cnt_to(3, 1'b1, n);
    check(n, 32);
    check(secured, 1'b0);
    $display("test power-on release done");
    rd[0] = half_clk;
    @(posedge system_clock);
    #1;
    check(half_clk, !rd[0]);
    rd_chk(8'h00, 32'h00000000);
    rd_chk(8'h04, 32'h0000ffff);
    rd_chk(8'h0c, 32'h00000000);
    sel_v = 4'h2;
    wb(1'b1, 8'h04, 16'h00c3);
    rd_chk(8'h04, 32'h000000ff);
    sel_v = 4'h3;
    wb(1'b1, 8'h04, 16'h00a5);
    check(periph_clk_en, 16'h00a5);
    rd_chk(8'h04, 32'h000000a5);
    check({core_clk_en, wdog_clk_en, clk_out_en}, 3'b111);
    wb(1'b1, 8'h00, 16'h0060);
    check({debug_enable, clk_out_en}, 2'b10);
    $display("test registers done");
    core_u.sleep(1'b0);
    #1;
    check({power_mode, core_clk_en, periph_clk_en}, {rpm_pkg::MODE_WAIT, 1'b0, 16'h00a5});
    core_u.irq(3);
    #1;
    check({power_mode, core_clk_en}, {rpm_pkg::MODE_RUN, 1'b1});
    core_u.sleep(1'b1);
    #1;
    check({power_mode, periph_clk_en, wdog_clk_en}, {rpm_pkg::MODE_STOP, 16'h0000, 1'b1});
    core_u.irq(3);
    #1;
    check(power_mode, rpm_pkg::MODE_STOP);
    @(posedge system_clock);
    nonclk_irq <= 1'b1;
    #1;
    cnt_to(4, 1'b1, n);
    check(n <= 8 && can_drop_first === 1'b0, 1'b1);
    @(posedge system_clock);
    nonclk_irq <= 1'b0;
    // synced interrupt must fall first, or it ends the next stop
    repeat (6) @(posedge system_clock);
    core_u.sleep(1'b1);
    can_rx_activity <= 1'b1;
    #1;
    cnt_to(4, 1'b1, n);
    check(n <= 8, 1'b1);
    @(posedge system_clock);
    can_rx_activity <= 1'b0;
    #1;
    check(can_drop_first, 1'b1);
    core_u.msg_done();
    #1;
    check(can_drop_first, 1'b0);
    $display("test power modes done");
    wb(1'b1, 8'h00, 16'h0005);
    core_u.sleep(1'b1);
    core_u.sleep(1'b0);
    #1;
    check(power_mode, rpm_pkg::MODE_RUN);
    wb(1'b1, 8'h00, 16'h0002);
    wb(1'b1, 8'h00, 16'h0000);
    rd_chk(8'h00, 32'h00000002);
    core_u.sleep(1'b1);
    #1;
    check(power_mode, rpm_pkg::MODE_RUN);
    $display("test sleep disable done");
    wb(1'b1, 8'h00, 16'h0010);
    cnt_to(2, 1'b0, n);
    check(n <= 4 && sim_clk_run === 1'b1, 1'b1);
    seq_chk();
    rd_chk(8'h00, 32'h00000000);
    rd_chk(8'h04, 32'h0000ffff);
    sec_byte0 <= 8'h00;
    pulse_wdog();
    cnt_to(2, 1'b0, n);
    check(n <= 4, 1'b1);
    repeat (40) @(posedge system_clock);
    pulse_wdog();
    cnt_to(1, 1'b0, n);
    cnt_to(1, 1'b1, n);
    check(n >= 28 && n <= 34, 1'b1);
    cnt_to(3, 1'b1, n);
    wb(1'b1, 8'h00, 16'h0040);
    check({secured, debug_enable, core_fetch_en}, 3'b101);
    rd_chk(8'h08, 32'h00000034);
    $display("test synchronous resets done");
    sec_byte0 <= 8'hff;
    sec_byte1 <= 8'h7f;
    core_u.sleep(1'b1);
    @(posedge system_clock);
    ext_reset_n <= 1'b0;
    #1;
    check({core_rst_n, periph_rst_n}, 2'b00);
    repeat (6) @(posedge system_clock);
    ext_reset_n <= 1'b1;
    #1;
    check({core_rst_n, pick(4)}, 2'b01);
    seq_chk();
    check(secured, 1'b1);
    $display("test external reset done");
    report_and_stop();
  end
endmodule
